// [bench/ccf_top_bench.sv]
// self-checking bench for the condition flag block, one task per scenario
// assumes ccf_pkg and ccf_top compiled first; checker bound from its own file
`timescale 1ns/1ps
module ccf_top_bench;
  import ccf_pkg::*;
  logic        ref_clk, rst_b, br_taken, insn_boundary, irq_pending, irq_stacked, irq_take, reg_wr, reg_rd;
  ccf_req_t    op_req;
  ccf_br_t     br_sel;
  logic [15:0] op_result;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, condition_flags;
  int          errors, compares;

  ccf_top dut (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .op_req          (op_req),
    .op_result       (op_result),
    .br_sel          (br_sel),
    .br_taken        (br_taken),
    .insn_boundary   (insn_boundary),
    .irq_pending     (irq_pending),
    .irq_stacked     (irq_stacked),
    .irq_take        (irq_take),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .condition_flags (condition_flags)
  );

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // register write, then register read judged in the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // one op for one cycle; flags settle on the edge that ends it
  task automatic op(input ccf_op_t o, input logic [15:0] a, input logic [15:0] b = 16'h0000,
                    input logic w = 1'b0, input logic bi = 1'b0);
    @(posedge ref_clk);
    op_req <= '{op: o, wide: w, a: a, b: b, bit_in: bi};
    @(posedge ref_clk);
    op_req.op <= CCF_OP_NONE;
    #1;
  endtask
  task automatic fl(input logic [7:0] m, input logic [7:0] exp);
    chk("condition_flags", {8'h00, condition_flags & m}, {8'h00, exp});
  endtask

  // boundary pulse with the take decision judged inside it
  task automatic bnd(input logic exp);
    @(posedge ref_clk);
    insn_boundary <= 1'b1;
    #1 chk("irq_take", {15'h0000, irq_take}, {15'h0000, exp});
    @(posedge ref_clk);
    insn_boundary <= 1'b0;
  endtask

  task automatic t_regs;
    rd(CCF_REG_OFFSET, CCF_RESET_VAL);
    rd(8'h01, 8'h00);
    wr(CCF_REG_OFFSET, 8'h00);
    wr(8'h01, 8'hff);
    rd(CCF_REG_OFFSET, CCF_FIXED_ONES);
    wr(CCF_REG_OFFSET, 8'h9f);
    rd(CCF_REG_OFFSET, 8'hff);
  endtask

  task automatic t_arith;
    op(CCF_OP_ADD, 16'h007f, 16'h0001);
    fl(8'h97, 8'h94);
    op(CCF_OP_ADD, 16'h00ff, 16'h0001);
    fl(8'h97, 8'h13);
    op(CCF_OP_ADC, 16'h000e, 16'h0001);
    fl(8'h97, 8'h10);
    op(CCF_OP_ADD, 16'h0010, 16'h0020);
    fl(8'h97, 8'h00);
    op(CCF_OP_SUB, 16'h0000, 16'h0001);
    fl(8'h87, 8'h05);
    op(CCF_OP_SBC, 16'h0080, 16'h0000);
    fl(8'h87, 8'h80);
    op(CCF_OP_LOAD, 16'h0080);
    fl(8'h86, 8'h04);
    op(CCF_OP_LOAD, 16'h0100, 16'h0000, 1'b1);
    fl(8'h86, 8'h00);
    op(CCF_OP_LOGIC, 16'h0000, 16'h0000, 1'b1);
    fl(8'h86, 8'h02);
    op(CCF_OP_ADD, 16'h0019, 16'h0028);
    op(CCF_OP_DADJ, 16'h0041);
    chk("op_result", {8'h00, op_result[7:0]}, 16'h0047);
    op(CCF_OP_ADD, 16'h0091, 16'h0091);
    op(CCF_OP_DADJ, 16'h0022);
    chk("op_result", {8'h00, op_result[7:0]}, 16'h0082);
    op(CCF_OP_SHL, 16'h0081);
    fl(8'h01, 8'h01);
    op(CCF_OP_SHR, 16'h0002);
    fl(8'h01, 8'h00);
    op(CCF_OP_BITC, 16'h0000, 16'h0000, 1'b0, 1'b1);
    fl(8'h01, 8'h01);
    op(CCF_OP_CLRC, 16'h0000);
    fl(8'h01, 8'h00);
    op(CCF_OP_SETC, 16'h0000);
    fl(8'h01, 8'h01);
  endtask

  // signed branches over three flag patterns; expected bits are gt ge le lt
  task automatic t_br;
    logic [7:0] fv [3] = '{8'h80, 8'h84, 8'h86};
    logic [3:0] ex [3] = '{4'b0011, 4'b1100, 4'b0110};
    for (int k = 0; k < 3; k++) begin
      wr(CCF_REG_OFFSET, fv[k]);
      for (int j = 0; j < 4; j++) begin
        @(posedge ref_clk);
        br_sel <= ccf_br_t'(4'(j + 1));
        #1 chk("br_taken", {15'h0000, br_taken}, {15'h0000, ex[k][3 - j]});
      end
    end
    @(posedge ref_clk);
    br_sel <= CCF_BR_NONE;
  endtask

  task automatic t_irq;
    wr(CCF_REG_OFFSET, 8'h08);
    irq_pending <= 1'b1;
    bnd(1'b0);
    op(CCF_OP_CLRI, 16'h0000);
    bnd(1'b0);
    bnd(1'b1);
    @(posedge ref_clk);
    irq_stacked <= 1'b1;
    @(posedge ref_clk);
    irq_stacked <= 1'b0;
    #1 fl(8'h08, 8'h08);
    bnd(1'b0);
    wr(CCF_REG_OFFSET, 8'h00);
    bnd(1'b0);
    bnd(1'b1);
    op(CCF_OP_SETI, 16'h0000);
    bnd(1'b0);
  endtask

  // mid-run reset: flags and latched result go back to their reset values
  task automatic t_reset;
    op(CCF_OP_LOAD, 16'h1200);
    fl(8'hff, 8'h6a);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    #1 fl(8'hff, CCF_RESET_VAL);
    chk("op_result", op_result, 16'h0000);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(CCF_REG_OFFSET, CCF_RESET_VAL);
  endtask

  // main sequence: reset for four cycles, then the scenarios
  initial begin
    {rst_b, insn_boundary, irq_pending, irq_stacked, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata} = '0;
    op_req = '0;
    br_sel = CCF_BR_NONE;
    errors = 0;
    compares = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_arith;
    t_br;
    t_irq;
    t_reset;
    end_of_test;
  end

  // watchdog: the scenarios need about a hundred cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    end_of_test;
  end
endmodule

// [bench/ccf_top_props.sv]
// checker for the condition flag block, watching only the top ports
// assumes ccf_pkg is compiled first; bound onto ccf_top after the module
`timescale 1ns/1ps
module ccf_props
  import ccf_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire ccf_req_t   op_req,
  input wire ccf_br_t    br_sel,
  input wire logic       br_taken,
  input wire logic       insn_boundary,
  input wire logic       irq_stacked,
  input wire logic       irq_take,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] condition_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // byte sum of an add, and whether the add lands (a write wins)
  wire logic [8:0] sum    = {1'b0, op_req.a[7:0]} + {1'b0, op_req.b[7:0]};
  wire logic       add_go = (op_req.op == CCF_OP_ADD) && !reg_wr;
  // unmask holdoff seen from the ports: armed when the mask falls, spent at the next boundary
  logic            hold_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= 1'b0;
    end else if (insn_boundary) begin
      hold_r <= 1'b0;
    end else if ($fell(condition_flags[CCF_BIT_I])) begin
      hold_r <= 1'b1;
    end
  end

  AST_FIXED: assert property (condition_flags[6:5] == 2'b11)
    else $error("spare bits not one");
  AST_MASK: assert property (irq_take |-> insn_boundary && !condition_flags[CCF_BIT_I])
    else $error("interrupt taken while masked");
  AST_HOLD: assert property (irq_take |-> !hold_r && !$fell(condition_flags[CCF_BIT_I]))
    else $error("interrupt right after unmask");
  AST_STACK: assert property (irq_stacked |=> condition_flags[CCF_BIT_I])
    else $error("mask not set on entry");
  AST_CARRY: assert property (add_go |=> condition_flags[CCF_BIT_C] == $past(sum[8]))
    else $error("carry wrong");
  AST_NEG: assert property (add_go |=> condition_flags[CCF_BIT_N] == $past(sum[7]))
    else $error("negative wrong");
  AST_ZERO: assert property (add_go |=> condition_flags[CCF_BIT_Z] == ($past(sum[7:0]) == 8'h00))
    else $error("zero wrong");
  AST_BRLT: assert property (br_sel == CCF_BR_LT |-> br_taken == (condition_flags[2] ^ condition_flags[7]))
    else $error("less-than branch wrong");
  AST_READ: assert property (reg_rd && reg_addr == CCF_REG_OFFSET |=> reg_rdata == $past(condition_flags))
    else $error("read data wrong");
  cover property (irq_take);
  cover property (add_go && sum[8]);
  cover property ($fell(condition_flags[CCF_BIT_I]) && insn_boundary);
endmodule

bind ccf_top ccf_props u_props (.*);

// [hw/ccf_alu.sv]
// flag evaluation for one op: result and next flags from operands and old flags
// assumes the core routes operands here in the cycle the op executes
`timescale 1ns/1ps
module ccf_alu
  import ccf_pkg::*;
(
  input  wire ccf_req_t   req,
  input  wire ccf_flags_t cur,
  output ccf_flags_t      nxt,
  output logic [15:0]     result
);

  function automatic logic is_zero(input logic [15:0] v, input logic wide);
    is_zero = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
  endfunction

  function automatic logic msb(input logic [15:0] v, input logic wide);
    msb = wide ? v[15] : v[CCF_BIT_V];
  endfunction

  // byte add with nibble and full carry, used for add and subtract alike
  logic [4:0] lo_sum;
  logic [8:0] full_sum;
  logic [7:0] opb;
  logic       cin;
  logic       is_sub;
  logic [7:0] bcd_fix;

  always_comb begin
    is_sub   = (req.op == CCF_OP_SUB) || (req.op == CCF_OP_SBC);
    opb      = is_sub ? ~req.b[7:0] : req.b[7:0];
    cin      = 1'b0;
    if (req.op == CCF_OP_ADC) begin
      cin = cur.c;
    end else if (req.op == CCF_OP_SUB) begin
      cin = 1'b1;
    end else if (req.op == CCF_OP_SBC) begin
      cin = ~cur.c;
    end
    lo_sum   = {1'b0, req.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    full_sum = {1'b0, req.a[7:0]} + {1'b0, opb} + {8'h00, cin};
  end

  // decimal correction from the half-carry and carry left by the prior add
  always_comb begin
    bcd_fix = 8'h00;
    if (cur.h || (req.a[3:0] > CCF_BCD_DIGIT_MAX)) begin
      bcd_fix = bcd_fix | CCF_BCD_LO_FIX;
    end
    if (cur.c || (req.a[7:0] > CCF_BCD_BYTE_MAX)) begin
      bcd_fix = bcd_fix | CCF_BCD_HI_FIX;
    end
  end

  always_comb begin
    nxt    = cur;
    result = req.a;
    case (req.op)
      CCF_OP_ADD, CCF_OP_ADC, CCF_OP_SUB, CCF_OP_SBC: begin
        result = {8'h00, full_sum[7:0]};
        nxt.v  = (req.a[7] == opb[7]) && (full_sum[7] != req.a[7]);
        if (!is_sub) begin
          nxt.h = lo_sum[4];
        end
        nxt.c  = is_sub ? ~full_sum[8] : full_sum[8];
        nxt.n  = full_sum[7];
        nxt.z  = (full_sum[7:0] == 8'h00);
      end
      CCF_OP_LOGIC: begin
        nxt.v = 1'b0;
        nxt.n = msb(req.a, req.wide);
        nxt.z = is_zero(req.a, req.wide);
      end
      CCF_OP_LOAD: begin
        nxt.v = 1'b0;
        nxt.n = msb(req.a, req.wide);
        nxt.z = is_zero(req.a, req.wide);
      end
      CCF_OP_DADJ: begin
        result = {8'h00, req.a[7:0] + bcd_fix};
        nxt.c  = cur.c | bcd_fix[CCF_BIT_U6];
        nxt.n  = result[7];
        nxt.z  = (result[7:0] == 8'h00);
      end
      CCF_OP_SHL: begin
        result = {8'h00, req.a[6:0], 1'b0};
        nxt.c  = req.a[7];
        nxt.n  = result[7];
        nxt.z  = (result[7:0] == 8'h00);
        nxt.v  = result[7] ^ req.a[7];
      end
      CCF_OP_SHR: begin
        result = {8'h00, 1'b0, req.a[7:1]};
        nxt.c  = req.a[0];
        nxt.n  = 1'b0;
        nxt.z  = (result[7:0] == 8'h00);
        nxt.v  = req.a[0];
      end
      CCF_OP_BITC: nxt.c = req.bit_in;
      CCF_OP_SETC: nxt.c = 1'b1;
      CCF_OP_CLRC: nxt.c = 1'b0;
      CCF_OP_SETI: nxt.i = 1'b1;
      CCF_OP_CLRI: nxt.i = 1'b0;
      default: nxt = cur;
    endcase
  end

endmodule

// [hw/ccf_branch.sv]
// signed branch condition evaluation from the stored flags
// assumes the branch is judged on flags present in the same cycle
`timescale 1ns/1ps
module ccf_branch
  import ccf_pkg::*;
(
  input  wire ccf_br_t    br,
  input  wire ccf_flags_t fl,
  output logic            taken
);

  logic lt;

  // signed compare uses negative xor overflow
  always_comb begin
    lt    = fl.n ^ fl.v;
    taken = 1'b0;
    case (br)
      CCF_BR_GT: taken = ~(fl.z | lt);
      CCF_BR_GE: taken = ~lt;
      CCF_BR_LE: taken = fl.z | lt;
      CCF_BR_LT: taken = lt;
      default:   taken = 1'b0;
    endcase
  end

endmodule

// [hw/ccf_pkg.sv]
// package for the condition flag block: field positions, reset values, op codes
// assumes an 8-bit core that presents one flag-affecting op per cycle
package ccf_pkg;

  localparam int unsigned CCF_BIT_V = 7;
  localparam int unsigned CCF_BIT_U6 = 6;
  localparam int unsigned CCF_BIT_U5 = 5;
  localparam int unsigned CCF_BIT_H = 4;
  localparam int unsigned CCF_BIT_I = 3;
  localparam int unsigned CCF_BIT_N = 2;
  localparam int unsigned CCF_BIT_Z = 1;
  localparam int unsigned CCF_BIT_C = 0;
  localparam logic [7:0] CCF_FIXED_ONES = 8'h60;
  localparam logic [7:0] CCF_RESET_VAL = 8'h68;
  localparam logic [7:0] CCF_REG_OFFSET = 8'h00;
  localparam logic [7:0] CCF_BCD_LO_FIX = 8'h06;
  localparam logic [7:0] CCF_BCD_HI_FIX = 8'h60;
  localparam logic [3:0] CCF_BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] CCF_BCD_BYTE_MAX = 8'h99;

  typedef enum logic [3:0] {
    CCF_OP_NONE  = 4'h0,
    CCF_OP_ADD   = 4'h1,
    CCF_OP_ADC   = 4'h2,
    CCF_OP_SUB   = 4'h3,
    CCF_OP_SBC   = 4'h4,
    CCF_OP_LOGIC = 4'h5,
    CCF_OP_LOAD  = 4'h6,
    CCF_OP_DADJ  = 4'h7,
    CCF_OP_SHL   = 4'h8,
    CCF_OP_SHR   = 4'h9,
    CCF_OP_SETC  = 4'ha,
    CCF_OP_CLRC  = 4'hb,
    CCF_OP_SETI  = 4'hc,
    CCF_OP_CLRI  = 4'hd,
    CCF_OP_BITC  = 4'he
  } ccf_op_t;

  typedef enum logic [3:0] {
    CCF_BR_NONE = 4'h0,
    CCF_BR_GT   = 4'h1,
    CCF_BR_GE   = 4'h2,
    CCF_BR_LE   = 4'h3,
    CCF_BR_LT   = 4'h4
  } ccf_br_t;

  typedef struct packed {
    ccf_op_t     op;
    logic        wide;
    logic [15:0] a;
    logic [15:0] b;
    logic        bit_in;
  } ccf_req_t;

  typedef struct packed {
    logic       v;
    logic       h;
    logic       i;
    logic       n;
    logic       z;
    logic       c;
  } ccf_flags_t;

endpackage

// [hw/ccf_top.sv]
// condition flag register of an 8-bit core with interrupt gating
// assumes one op per cycle, a boundary strobe per instruction, plain register port
//
// Function
// - six flags packed into one byte
// - overflow set on signed overflow, and from bit zero on right shifts
// - signed branches judged with overflow flag
// - half-carry from bit three on adds
// - decimal adjust corrects using half-carry, carry
// - mask set blocks all maskable interrupts
// - mask set automatically on interrupt entry
// - no interrupt at boundary after clearing mask
// - negative follows result bit seven
// - loads and stores set negative from msb
// - zero set for all-zero result
// - loads and stores set zero if zero
// - carry on add carry-out or borrow
// - shifts and bit tests update carry
`timescale 1ns/1ps
module ccf_top
  import ccf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire ccf_req_t    op_req,
  output logic [15:0]      op_result,
  input  wire ccf_br_t     br_sel,
  output logic             br_taken,
  input  wire logic        insn_boundary,
  input  wire logic        irq_pending,
  input  wire logic        irq_stacked,
  output logic             irq_take,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic [7:0]       condition_flags
);

  ccf_flags_t flags_r;
  ccf_flags_t flags_nxt;
  ccf_flags_t alu_flags;
  logic [15:0] alu_result;
  logic       mask_cleared_r;
  logic       wr_hit;
  logic       mask_clear_now;

  function automatic logic [7:0] pack_flags(input ccf_flags_t f);
    logic [7:0] b;
    b = CCF_FIXED_ONES;
    b[CCF_BIT_V] = f.v;
    b[CCF_BIT_H] = f.h;
    b[CCF_BIT_I] = f.i;
    b[CCF_BIT_N] = f.n;
    b[CCF_BIT_Z] = f.z;
    b[CCF_BIT_C] = f.c;
    return b;
  endfunction

  function automatic ccf_flags_t unpack_flags(input logic [7:0] b);
    ccf_flags_t f;
    f.v = b[CCF_BIT_V];
    f.h = b[CCF_BIT_H];
    f.i = b[CCF_BIT_I];
    f.n = b[CCF_BIT_N];
    f.z = b[CCF_BIT_Z];
    f.c = b[CCF_BIT_C];
    return f;
  endfunction

  ccf_alu u_alu (
    .req    (op_req),
    .cur    (flags_r),
    .nxt    (alu_flags),
    .result (alu_result)
  );

  ccf_branch u_branch (
    .br    (br_sel),
    .fl    (flags_r),
    .taken (br_taken)
  );

  assign wr_hit = reg_wr && (reg_addr == CCF_REG_OFFSET);

  // next flags: register write, then interrupt entry mask, else the op's flags
  always_comb begin
    flags_nxt = alu_flags;
    if (wr_hit) begin
      flags_nxt = unpack_flags(reg_wdata);
    end
    if (irq_stacked) begin
      flags_nxt.i = 1'b1;
    end
  end

  // a clear of a set mask, by op or by register write
  assign mask_clear_now = flags_r.i && !flags_nxt.i;

  // flag register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= unpack_flags(CCF_RESET_VAL);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // hold off recognition until the boundary after the clearing instruction passes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_cleared_r <= 1'b0;
    end else if (mask_clear_now) begin
      mask_cleared_r <= 1'b1;
    end else if (insn_boundary) begin
      mask_cleared_r <= 1'b0;
    end
  end

  // interrupt recognised only at boundaries with the mask clear
  assign irq_take = irq_pending && insn_boundary && !flags_r.i && !mask_cleared_r;

  // op result latched for the datapath
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_result <= 16'h0000;
    end else if (op_req.op != CCF_OP_NONE) begin
      op_result <= alu_result;
    end
  end

  // read data one cycle after the read strobe, zero when unmapped or idle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && (reg_addr == CCF_REG_OFFSET)) begin
      reg_rdata <= pack_flags(flags_r);
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign condition_flags = pack_flags(flags_r);

endmodule
